// *** design/uwci_pkg.sv ***
// package: register map, field layout and types of the usb wrapper block
`default_nettype none
package uwci_pkg;
  // ---------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_WRAPPER_CONTROL = 8'h04;
  localparam logic [7:0] OFS_WRAPPER_STATUS = 8'h08;
  localparam logic [7:0] OFS_EP_AGGREGATION = 8'h10;
  localparam logic [7:0] OFS_RX_AUTO_REQUEST = 8'h14;
  localparam logic [7:0] OFS_IRQ_SOURCE = 8'h20;
  localparam logic [7:0] OFS_IRQ_SOURCE_SET = 8'h24;
  localparam logic [7:0] OFS_IRQ_SOURCE_CLEAR = 8'h28;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h2c;
  localparam logic [7:0] OFS_IRQ_MASK_SET = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK_CLEAR = 8'h34;
  localparam logic [7:0] OFS_IRQ_MASKED_SOURCE = 8'h38;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL_SOFT_RESET_BIT = 0;
  localparam int CTL_QUICK_ACK_BIT = 1;
  localparam int CTL_IRQ_PATH_BIT = 3;
  localparam int CTL_AGGREGATION_BIT = 4;
  localparam int STAT_VBUS_BIT = 0;
  localparam int AGG_TX_LSB = 0;
  localparam int AGG_RX_LSB = 16;
  localparam int IRQ_TX_LSB = 0;
  localparam int IRQ_RX_LSB = 9;
  localparam int IRQ_CORE_LSB = 16;
  localparam int IRQ_TX_W = 5;
  localparam int IRQ_RX_W = 4;
  localparam int IRQ_CORE_W = 9;
  localparam int EP_COUNT = 4;
  // ---------------------------------------------------------------
  // reset values and timing
  // ---------------------------------------------------------------
  localparam logic [31:0] RST_IRQ_MASK = 32'h0000_0000;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] IRQ_VALID_BITS = 32'h01ff_1e1f;
  localparam int SOFT_RESET_CYCLES = 16;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    UWCI_AREQ_NONE = 2'h0,
    UWCI_AREQ_NOT_EOP = 2'h1,
    UWCI_AREQ_RSVD = 2'h2,
    UWCI_AREQ_ALWAYS = 2'h3
  } uwci_areq_e;
  typedef enum logic [1:0] {
    UWCI_ST_RUN = 2'b01,
    UWCI_ST_SOFT_RESET = 2'b10
  } uwci_state_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uwci_bus_s;
  typedef struct packed {
    logic aggregation_all;
    logic core_irq_path_select;
    logic clock_stop_quick_ack;
    logic [EP_COUNT-1:0] rx_aggregation_en;
    logic [EP_COUNT-1:0] tx_aggregation_en;
    logic [2*EP_COUNT-1:0] rx_auto_request;
    logic core_reset;
  } uwci_cfg_s;
  typedef struct packed {
    uwci_state_e state;
    logic [7:0] rst_count;
    logic [4:0] control;
    logic [31:0] ep_aggregation;
    logic [7:0] auto_request;
    logic [31:0] irq_source;
    logic [31:0] irq_mask;
    logic [31:0] rdata;
    logic [2:0] vbus_sync;
    logic vbus_level;
  } uwci_state_s;
endpackage
`default_nettype wire

// *** design/uwci_ctrl_irq.sv ***
// usb wrapper control registers and interrupt aggregation
// Contract
// RULE1: writing one to control bit 0 starts a module reset, zero does nothing; a one written in the last cycle of a running reset is lost.
// RULE2: the soft reset bit clears itself when the module reset is over.
// RULE3: control bit 4 turns packet aggregation on for all endpoints.
// RULE4: control bit 3 picks the core's own irq path when one.
// RULE5: control bit 1 enables quick acknowledge of clock stop requests.
// RULE6: status bit 0 reads the present level of the vbus drive output.
// RULE7: aggregation enables sit in bits 19:16 (rx) and 3:0 (tx).
// RULE8: each rx endpoint has a 2-bit auto request field, ep4 in bits 7:6.
// RULE9: irq source reports core 24:16, rx 12:9 and tx 4:0.
// RULE10: a one written to source-set forces that source active.
// RULE11: a one written to source-clear deactivates that source.
// RULE12: the read-only mask holds one enable per source, same layout.
// RULE13: a one written to mask-set sets that mask bit.
// RULE14: a one written to mask-clear clears that mask bit.
// RULE15: the masked source reads source AND mask bit for bit.
// RULE16: zeros written to any set or clear register change nothing.
// RULE17: the irq output is high while any masked source bit is set.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`default_nettype none
module uwci_ctrl_irq #(
  parameter int RESET_CYCLES = uwci_pkg::SOFT_RESET_CYCLES
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire uwci_pkg::uwci_bus_s bus,
  output logic [31:0] rdata,
  input wire logic [31:0] core_irq_event,
  input wire logic vbus_drive_output,
  output uwci_pkg::uwci_cfg_s cfg,
  output logic irq
);
  import uwci_pkg::*;

  // the sequencer counter is eight bits wide
  if (RESET_CYCLES < 1 || RESET_CYCLES > 255) begin : g_bad_cycles
    $error("RESET_CYCLES out of range");
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic hit(input uwci_bus_s b, input logic [7:0] ofs);
    hit = (b.addr == ofs);
  endfunction

  localparam logic [7:0] RESET_LAST = 8'(RESET_CYCLES - 1);

  uwci_state_s st;
  uwci_state_s next_st;
  logic [31:0] masked;

  assign masked = st.irq_source & st.irq_mask; // [RULE15]

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [31:0] src_set;
    logic [31:0] src_clr;
    logic [31:0] msk_set;
    logic [31:0] msk_clr;
    next_st = st;
    src_set = 32'h0000_0000;
    src_clr = 32'h0000_0000;
    msk_set = 32'h0000_0000;
    msk_clr = 32'h0000_0000;
    next_st.vbus_sync = {st.vbus_sync[1:0], vbus_drive_output};
    // a change counts only once the second and third stages agree
    if (st.vbus_sync[1] == st.vbus_sync[2]) begin
      next_st.vbus_level = st.vbus_sync[2]; // [RULE6]
    end
    // register writes
    if (bus.wr) begin
      if (hit(bus, OFS_WRAPPER_CONTROL)) begin
        next_st.control[CTL_AGGREGATION_BIT] =
          bus.wdata[CTL_AGGREGATION_BIT]; // [RULE3]
        next_st.control[CTL_IRQ_PATH_BIT] =
          bus.wdata[CTL_IRQ_PATH_BIT]; // [RULE4]
        next_st.control[CTL_QUICK_ACK_BIT] =
          bus.wdata[CTL_QUICK_ACK_BIT]; // [RULE5]
        if (bus.wdata[CTL_SOFT_RESET_BIT]) begin
          next_st.control[CTL_SOFT_RESET_BIT] = 1'b1; // [RULE1]
          next_st.state = UWCI_ST_SOFT_RESET;
          next_st.rst_count = 8'h00;
        end
      end else if (hit(bus, OFS_EP_AGGREGATION)) begin
        next_st.ep_aggregation = RST_ZERO;
        next_st.ep_aggregation[AGG_RX_LSB +: EP_COUNT] =
          bus.wdata[AGG_RX_LSB +: EP_COUNT]; // [RULE7]
        next_st.ep_aggregation[AGG_TX_LSB +: EP_COUNT] =
          bus.wdata[AGG_TX_LSB +: EP_COUNT]; // [RULE7]
      end else if (hit(bus, OFS_RX_AUTO_REQUEST)) begin
        next_st.auto_request = bus.wdata[7:0]; // [RULE8]
      end else if (hit(bus, OFS_IRQ_SOURCE_SET)) begin
        src_set = bus.wdata & IRQ_VALID_BITS; // [RULE10] [RULE16]
      end else if (hit(bus, OFS_IRQ_SOURCE_CLEAR)) begin
        src_clr = bus.wdata & IRQ_VALID_BITS; // [RULE11] [RULE16]
      end else if (hit(bus, OFS_IRQ_MASK_SET)) begin
        msk_set = bus.wdata & IRQ_VALID_BITS; // [RULE13] [RULE16]
      end else if (hit(bus, OFS_IRQ_MASK_CLEAR)) begin
        msk_clr = bus.wdata & IRQ_VALID_BITS; // [RULE14] [RULE16]
      end
    end
    // a core event in the same cycle as a clear still sets the source
    next_st.irq_source = ((st.irq_source & ~src_clr) | src_set |
      (core_irq_event & IRQ_VALID_BITS)); // [RULE9] [RULE11]
    next_st.irq_mask = (st.irq_mask & ~msk_clr) | msk_set; // [RULE12]
    // soft reset sequencer
    case (st.state)
      UWCI_ST_RUN: begin
        next_st.state = next_st.state;
      end
      UWCI_ST_SOFT_RESET: begin
        if (st.rst_count == RESET_LAST) begin
          next_st.state = UWCI_ST_RUN;
          next_st.control[CTL_SOFT_RESET_BIT] = 1'b0; // [RULE2]
          next_st.rst_count = 8'h00;
        end else begin
          next_st.rst_count = st.rst_count + 8'h01;
        end
      end
      default: begin
        next_st.state = UWCI_ST_RUN;
      end
    endcase
    // register reads, data in the following cycle
    next_st.rdata = RST_ZERO;
    if (bus.rd) begin
      if (hit(bus, OFS_WRAPPER_CONTROL)) begin
        next_st.rdata = {27'h000_0000, st.control};
      end else if (hit(bus, OFS_WRAPPER_STATUS)) begin
        next_st.rdata[STAT_VBUS_BIT] = st.vbus_level; // [RULE6]
      end else if (hit(bus, OFS_EP_AGGREGATION)) begin
        next_st.rdata = st.ep_aggregation;
      end else if (hit(bus, OFS_RX_AUTO_REQUEST)) begin
        next_st.rdata = {24'h00_0000, st.auto_request};
      end else if (hit(bus, OFS_IRQ_SOURCE)) begin
        next_st.rdata = st.irq_source; // [RULE9]
      end else if (hit(bus, OFS_IRQ_MASK)) begin
        next_st.rdata = st.irq_mask; // [RULE12]
      end else if (hit(bus, OFS_IRQ_MASKED_SOURCE)) begin
        next_st.rdata = masked; // [RULE15]
      end else begin
        next_st.rdata = RST_ZERO;
      end
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st.state <= UWCI_ST_RUN;
      st.rst_count <= 8'h00;
      st.control <= 5'h00;
      st.ep_aggregation <= RST_ZERO;
      st.auto_request <= 8'h00;
      st.irq_source <= RST_ZERO;
      st.irq_mask <= RST_IRQ_MASK;
      st.rdata <= RST_ZERO;
      st.vbus_sync <= 3'h0;
      st.vbus_level <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata = st.rdata;
  assign irq = |masked; // [RULE17]
  assign cfg.aggregation_all = st.control[CTL_AGGREGATION_BIT]; // [RULE3]
  assign cfg.core_irq_path_select = st.control[CTL_IRQ_PATH_BIT]; // [RULE4]
  assign cfg.clock_stop_quick_ack = st.control[CTL_QUICK_ACK_BIT]; // [RULE5]
  assign cfg.rx_aggregation_en = st.ep_aggregation[AGG_RX_LSB +: EP_COUNT];
  assign cfg.tx_aggregation_en = st.ep_aggregation[AGG_TX_LSB +: EP_COUNT];
  assign cfg.rx_auto_request = st.auto_request; // [RULE8]
  // core held in reset while the soft reset runs
  assign cfg.core_reset = (st.state == UWCI_ST_SOFT_RESET); // [RULE1]
endmodule
`default_nettype wire

// *** tb/uwci_ctrl_irq_asserts.sv ***
// checker for the wrapper register and interrupt ports
`default_nettype none
module uwci_ctrl_irq_asserts #(
  parameter int RESET_CYCLES = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire uwci_pkg::uwci_bus_s bus,
  input wire logic [31:0] rdata,
  input wire logic [31:0] core_irq_event,
  input wire logic vbus_drive_output,
  input wire uwci_pkg::uwci_cfg_s cfg,
  input wire logic irq
);
  import uwci_pkg::*;
  // ----
  // helpers
  // ----
  logic [7:0] rc;
  wire logic wc = bus.wr && bus.addr == OFS_WRAPPER_CONTROL;
  wire logic [31:0] wd = bus.wdata;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rc <= 8'h00;
    end else begin
      rc <= cfg.core_reset ? rc + 8'h01 : 8'h00;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_go; wc && wd[0] |=> cfg.core_reset; endproperty
  a_go: assert property (p_go) else $error("no reset");
  property p_hold; cfg.core_reset && rc < RESET_CYCLES - 1 |=> cfg.core_reset;
  endproperty
  a_hold: assert property (p_hold) else $error("short reset");
  property p_end; cfg.core_reset && rc == RESET_CYCLES - 1 |=> !cfg.core_reset;
  endproperty
  a_end: assert property (p_end) else $error("long reset");
  property p_ctl; wc |=> cfg.aggregation_all == $past(wd[4])
    && cfg.core_irq_path_select == $past(wd[3])
    && cfg.clock_stop_quick_ack == $past(wd[1]); endproperty
  a_ctl: assert property (p_ctl) else $error("ctl");
  property p_agg; bus.wr && bus.addr == OFS_EP_AGGREGATION |=>
    {cfg.rx_aggregation_en, cfg.tx_aggregation_en} ==
    {$past(wd[19:16]), $past(wd[3:0])}; endproperty
  a_agg: assert property (p_agg) else $error("agg");
  property p_areq; bus.wr && bus.addr == OFS_RX_AUTO_REQUEST |=>
    cfg.rx_auto_request == $past(wd[7:0]); endproperty
  a_areq: assert property (p_areq) else $error("areq");
  property p_rise; $rose(irq) |-> $past(core_irq_event != 0 || bus.wr &&
    (bus.addr == OFS_IRQ_SOURCE_SET || bus.addr == OFS_IRQ_MASK_SET));
  endproperty
  a_rise: assert property (p_rise) else $error("irq");
  property p_set; bus.wr && bus.addr == OFS_IRQ_SOURCE_SET ##1 !bus.wr
    ##1 bus.rd && bus.addr == OFS_IRQ_SOURCE |=>
    (rdata & $past(wd, 3) & IRQ_VALID_BITS) == ($past(wd, 3) & IRQ_VALID_BITS);
  endproperty
  a_set: assert property (p_set) else $error("set");
  property p_rsvd; bus.rd && (bus.addr == OFS_IRQ_SOURCE || bus.addr ==
    OFS_IRQ_MASK || bus.addr == OFS_IRQ_MASKED_SOURCE) |=>
    (rdata & ~IRQ_VALID_BITS) == 32'h0000_0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("rsvd");
  c_go: cover property (wc && wd[0]);
  c_rise: cover property ($rose(irq));
  c_fall: cover property ($fell(irq));
endmodule
`default_nettype wire

// *** tb/tb_uwci_ctrl_irq.sv ***
// testbench for the wrapper registers, soft reset and interrupts
`default_nettype none
module tb_uwci_ctrl_irq;
  timeunit 1ns;
  timeprecision 1ns;
  import uwci_pkg::*;
  // ----
  // harness
  // ----
  localparam int RC = 4; // short soft reset keeps the run brief
  typedef struct packed {logic [7:0] a; logic [31:0] d, e;} uwci_row_s;
  localparam uwci_row_s ROWS [11] = '{
    '{OFS_WRAPPER_CONTROL, 32'hffff_fffe, 32'h0000_001a},
    '{OFS_WRAPPER_CONTROL, 32'h0000_0008, 32'h0000_0008},
    '{OFS_WRAPPER_CONTROL, 32'h0000_0000, 32'h0000_0000},
    '{OFS_EP_AGGREGATION, 32'hffff_ffff, 32'h000f_000f},
    '{OFS_RX_AUTO_REQUEST, 32'hffff_ffff, 32'h0000_00ff},
    '{OFS_RX_AUTO_REQUEST, 32'h0000_00e4, 32'h0000_00e4},
    '{OFS_IRQ_SOURCE, 32'hffff_ffff, 32'h0000_0000},
    '{OFS_IRQ_MASK, 32'hffff_ffff, 32'h0000_0000},
    '{OFS_IRQ_MASKED_SOURCE, 32'hffff_ffff, 32'h0000_0000},
    '{OFS_WRAPPER_STATUS, 32'hffff_ffff, 32'h0000_0000},
    '{8'h7c, 32'hffff_ffff, 32'h0000_0000}};
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  uwci_bus_s bus = '0;
  logic [31:0] rdata;
  logic [31:0] core_irq_event = 32'h0000_0000;
  logic vbus_drive_output = 1'b0;
  uwci_cfg_s cfg;
  logic irq;
  int fails = 0;
  int samples_checked = 0;
  int n;
  always #10 clock = ~clock;
  uwci_ctrl_irq #(.RESET_CYCLES(RC)) u_dut (.clock(clock), .reset_n(reset_n),
    .bus(bus), .rdata(rdata), .core_irq_event(core_irq_event),
    .vbus_drive_output(vbus_drive_output), .cfg(cfg), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  // read data stand one cycle only, so sample just after the taking edge
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clock);
    bus.rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #1000000 fails++;
    print_verdict();
  end
  // ----
  // sequence
  // ----
  initial begin
    repeat (10) @(posedge clock);
    chk(32'({rdata[0], irq, cfg}), 32'h0);
    reset_n <= 1'b1;
    rd(OFS_IRQ_MASK, 32'h0000_0000);
    for (int i = 0; i < 11; i++) begin
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, ROWS[i].e);
    end
    wr(OFS_IRQ_SOURCE_SET, 32'hffff_ffff);
    rd(OFS_IRQ_SOURCE, 32'h01ff_1e1f);
    chk(32'(irq), 32'h0);
    wr(OFS_IRQ_MASK_SET, 32'h0000_0201);
    rd(OFS_IRQ_MASK, 32'h0000_0201);
    rd(OFS_IRQ_MASKED_SOURCE, 32'h0000_0201);
    chk(32'(irq), 32'h1);
    wr(OFS_IRQ_SOURCE_CLEAR, 32'h0000_0000);
    wr(OFS_IRQ_MASK_CLEAR, 32'h0000_0000);
    rd(OFS_IRQ_MASK, 32'h0000_0201);
    rd(OFS_IRQ_SOURCE, 32'h01ff_1e1f);
    wr(OFS_IRQ_MASK_CLEAR, 32'h0000_0001);
    rd(OFS_IRQ_MASK, 32'h0000_0200);
    wr(OFS_IRQ_SOURCE_CLEAR, 32'h0000_0200);
    rd(OFS_IRQ_SOURCE, 32'h01ff_1c1f);
    rd(OFS_IRQ_MASKED_SOURCE, 32'h0000_0000);
    chk(32'(irq), 32'h0);
    @(posedge clock);
    core_irq_event <= 32'h0000_0220; // bit 5 is reserved
    @(posedge clock);
    core_irq_event <= 32'h0000_0000;
    rd(OFS_IRQ_SOURCE, 32'h01ff_1e1f);
    chk(32'(irq), 32'h1);
    vbus_drive_output <= 1'b1;
    repeat (5) @(posedge clock);
    rd(OFS_WRAPPER_STATUS, 32'h0000_0001);
    wr(OFS_WRAPPER_CONTROL, 32'h0000_0001);
    n = 0;
    // the reset starts at the edge that takes the write, so count from it
    repeat (RC + 4) begin
      #1 if (cfg.core_reset === 1'b1) n++;
      @(posedge clock);
    end
    chk(32'(n), 32'(RC));
    rd(OFS_WRAPPER_CONTROL, 32'h0000_0000);
    wr(OFS_WRAPPER_CONTROL, 32'h0000_0001);
    rd(OFS_WRAPPER_CONTROL, 32'h0000_0001);
    for (n = 0; n < 20 && cfg.core_reset !== 1'b0; n++) @(posedge clock);
    chk(32'(cfg.core_reset), 32'h0);
    reset_n <= 1'b0; // mid-run reset drops the mask and the irq
    @(posedge clock);
    #1 chk(32'(irq), 32'h0);
    @(posedge clock);
    reset_n <= 1'b1;
    rd(OFS_IRQ_MASK, 32'h0000_0000);
    print_verdict();
  end
endmodule
bind uwci_ctrl_irq uwci_ctrl_irq_asserts #(.RESET_CYCLES(RESET_CYCLES)) u_chk (
  .clock(clock), .reset_n(reset_n), .bus(bus), .rdata(rdata),
  .core_irq_event(core_irq_event), .vbus_drive_output(vbus_drive_output),
  .cfg(cfg), .irq(irq));
`default_nettype wire
